// ---- pkg/cip_cfg.svh ----
// constants of the cpu interrupt priority and flag block
// assumes a 32-bit apb slave, one word per register, 16-bit data in the low bits
// How it works
// (RULE1) status bits 7-5 hold cpu priority
// (RULE2) top bit above status field gives 8-15
// (RULE3) level 7 or top bit set blocks all user interrupts
// (RULE4) nesting disable locks the status priority field
// (RULE5) core bit 3 reads level above 7, clear-only
// (RULE6) external flags at bits 13 and 4
// (RULE7) change, comparator, i2c flags at bits 3-0
// (RULE8) slave flag reads one after request; others zero
// (RULE9) adc pair priorities 6-4 and 2-0, reset 4
`ifndef CIP_CFG_SVH
`define CIP_CFG_SVH
`define CIP_OFF_STATUS 12'h000
`define CIP_OFF_CORE 12'h004
`define CIP_OFF_ICTL1 12'h008
`define CIP_OFF_FLAGS 12'h00C
`define CIP_OFF_ADCPRI 12'h010
`define CIP_OFF_IRQ_MASK 12'h014
`define CIP_OFF_LEVEL 12'h018
`define CIP_STATUS_IPL_LSB 5
`define CIP_CORE_TOP_BIT 3
`define CIP_ICTL1_NEST_BIT 15
`define CIP_FLAGS_IMPL 16'h201F
`define CIP_ADC3_LSB 4
`define CIP_ADC2_LSB 0
`define CIP_ADCPRI_RESET 16'h0044
`define CIP_ADCPRI_IMPL 16'h0077
`endif

// ---- pkg/cip_pkg.sv ----
// types of the cpu interrupt priority and flag block
// assumes the constants header is included by users of the offsets
package cip_pkg;
  typedef struct packed {
    logic [2:0] cpu_priority_low_bits;
    logic cpu_priority_top_bit;
    logic nesting_disable;
    logic [15:0] flags;
    logic [15:0] adc_pri;
    logic [15:0] irq_mask;
  } cip_regs_t;
  typedef struct packed {
    logic [15:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] level;
    logic user_block;
  } cip_out_t;
  typedef struct packed {
    cip_regs_t regs;
    cip_out_t outs;
  } cip_state_t;
endpackage : cip_pkg

// ---- design/cip_flag_merge.sv ----
// sticky flag merge: hardware set wins over software clear
// assumes set pulses and clear masks are synchronous to pclk
`timescale 1ns/1ns
module cip_flag_merge (
  // current and implemented bits
  input wire logic [15:0] cur,
  input wire logic [15:0] impl,
  // events and software actions
  input wire logic [15:0] set,
  input wire logic [15:0] clr,
  input wire logic [15:0] wr_mask,
  input wire logic [15:0] wr_val,
  // merged value
  output logic [15:0] nxt
);
  always_comb
  begin
    nxt = (((cur & ~clr) & ~wr_mask) | (wr_val & wr_mask) | set) & impl;
  end
endmodule : cip_flag_merge

// ---- design/cip_top.sv ----
// apb register block holding cpu priority, request flags and adc pair priorities
// assumes one clock pclk, asynchronous active-low presetn, event inputs one pclk wide
`include "cip_cfg.svh"
`timescale 1ns/1ns
module cip_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request events
  input wire logic ext_req_two,
  input wire logic ext_req_one,
  input wire logic change_req,
  input wire logic comparator_req,
  input wire logic i2c_master_req,
  input wire logic i2c_slave_req,
  // cpu side
  output logic [3:0] cpu_level,
  output logic user_irq_block,
  output logic irq
);
  cip_pkg::cip_state_t st;
  cip_pkg::cip_state_t next_st;
  logic [15:0] ev;
  logic [15:0] flag_clr;
  logic [15:0] flag_wmask;
  logic [15:0] flag_nxt;
  logic wr;
  logic rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `CIP_OFF_STATUS) || hit(a, `CIP_OFF_CORE) || hit(a, `CIP_OFF_ICTL1) ||
             hit(a, `CIP_OFF_FLAGS) || hit(a, `CIP_OFF_ADCPRI) ||
             hit(a, `CIP_OFF_IRQ_MASK) || hit(a, `CIP_OFF_LEVEL);
  endfunction : mapped

  // no wait state: read data and error are prepared in the setup cycle so that
  // they stand in the access cycle, together with pready
  assign wr = psel & penable & pwrite & st.outs.pready;
  assign rd = psel & ~penable & ~pwrite;

  always_comb
  begin
    ev = 16'h0000;
    ev[13] = ext_req_two; // see RULE6
    ev[4] = ext_req_one; // see RULE6
    ev[3] = change_req; // see RULE7
    ev[2] = comparator_req; // see RULE7
    ev[1] = i2c_master_req; // see RULE7
    ev[0] = i2c_slave_req; // see RULE8
  end

  // flags double as the interrupt status: plain write stores, status view clears on one
  always_comb
  begin
    flag_clr = 16'h0000;
    flag_wmask = 16'h0000;
    if (wr && hit(paddr, `CIP_OFF_FLAGS))
    begin
      flag_wmask = 16'hFFFF;
    end
    if (wr && hit(paddr, `CIP_OFF_LEVEL))
    begin
      flag_clr = pwdata[15:0];
    end
  end

  cip_flag_merge u_merge (
    .cur(st.regs.flags),
    .impl(`CIP_FLAGS_IMPL),
    .set(ev),
    .clr(flag_clr),
    .wr_mask(flag_wmask),
    .wr_val(pwdata[15:0]),
    .nxt(flag_nxt)
  ); // see RULE8

  always_comb
  begin
    next_st = st;
    next_st.regs.flags = flag_nxt;
    next_st.outs.pready = psel & ~penable;
    next_st.outs.pslverr = psel & ~penable & ~mapped(paddr);
    if (wr)
    begin
      case (paddr)
        `CIP_OFF_STATUS:
        begin
          if (!st.regs.nesting_disable) // see RULE4
          begin
            next_st.regs.cpu_priority_low_bits = pwdata[7:5]; // see RULE1
          end
        end
        `CIP_OFF_CORE:
        begin
          if (!pwdata[`CIP_CORE_TOP_BIT]) // see RULE5
          begin
            next_st.regs.cpu_priority_top_bit = 1'b0;
          end
        end
        `CIP_OFF_ICTL1:
        begin
          next_st.regs.nesting_disable = pwdata[`CIP_ICTL1_NEST_BIT];
        end
        `CIP_OFF_FLAGS:
        begin
        end
        `CIP_OFF_ADCPRI:
        begin
          next_st.regs.adc_pri = pwdata[15:0] & `CIP_ADCPRI_IMPL; // see RULE9
        end
        `CIP_OFF_IRQ_MASK:
        begin
          next_st.regs.irq_mask = pwdata[15:0] & `CIP_FLAGS_IMPL;
        end
        `CIP_OFF_LEVEL:
        begin
        end
        default:
        begin
        end
      endcase
    end
    next_st.outs.prdata = 16'h0000;
    if (rd)
    begin
      case (paddr)
        `CIP_OFF_STATUS:
          next_st.outs.prdata = {8'h00, st.regs.cpu_priority_low_bits, 5'h00}; // see RULE1
        `CIP_OFF_CORE:
          next_st.outs.prdata = {12'h000, st.regs.cpu_priority_top_bit, 3'h0}; // see RULE5
        `CIP_OFF_ICTL1:
          next_st.outs.prdata = {st.regs.nesting_disable, 15'h0000};
        `CIP_OFF_FLAGS:
          next_st.outs.prdata = st.regs.flags; // see RULE8
        `CIP_OFF_ADCPRI:
          next_st.outs.prdata = st.regs.adc_pri;
        `CIP_OFF_IRQ_MASK:
          next_st.outs.prdata = st.regs.irq_mask;
        `CIP_OFF_LEVEL:
          next_st.outs.prdata = st.regs.flags;
        default:
          next_st.outs.prdata = 16'h0000;
      endcase
    end
    // level is built from the next state, so it changes on the same edge as the write
    next_st.outs.level = {next_st.regs.cpu_priority_top_bit,
                          next_st.regs.cpu_priority_low_bits}; // see RULE2
    next_st.outs.user_block = next_st.regs.cpu_priority_top_bit |
                              (&next_st.regs.cpu_priority_low_bits); // see RULE3
    next_st.outs.irq = |(next_st.regs.flags & next_st.regs.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{regs: '{cpu_priority_low_bits: 3'h0, cpu_priority_top_bit: 1'b0,
                      nesting_disable: 1'b0, flags: 16'h0000,
                      adc_pri: `CIP_ADCPRI_RESET, irq_mask: 16'h0000},
              outs: '{prdata: 16'h0000, pready: 1'b0, pslverr: 1'b0, irq: 1'b0,
                      level: 4'h0, user_block: 1'b0}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = {16'h0000, st.outs.prdata};
  assign pready = st.outs.pready;
  assign pslverr = st.outs.pslverr;
  assign cpu_level = st.outs.level;
  assign user_irq_block = st.outs.user_block;
  assign irq = st.outs.irq;
endmodule : cip_top

// ---- tb/cip_asserts.sv ----
// checker for the cpu priority and flag block
// assumes it is bound onto cip_top and sees only its ports
`timescale 1ns/1ns
module cip_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // cpu side
  input wire logic [3:0] cpu_level,
  input wire logic user_irq_block
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = psel & penable & pready & !pwrite;
  property p_blk; user_irq_block == (cpu_level[3] | &cpu_level[2:0]); endproperty
  a_blk: assert property (p_blk) else $error("block flag wrong");
  property p_top; !cpu_level[3]; endproperty
  a_top: assert property (p_top) else $error("top bit set");
  property p_sts; rd && paddr == 12'h000 |-> prdata[7:5] == cpu_level[2:0]; endproperty
  a_sts: assert property (p_sts) else $error("status level wrong");
  property p_flg; rd && paddr == 12'h00C |-> (prdata & ~32'h201F) == 32'h0; endproperty
  a_flg: assert property (p_flg) else $error("flag spare bits");
  property p_adc; rd && paddr == 12'h010 |-> (prdata & ~32'h77) == 32'h0; endproperty
  a_adc: assert property (p_adc) else $error("adc spare bits");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("not ready");
  property p_idl; !(psel && !penable) |=> prdata == 32'h0; endproperty
  a_idl: assert property (p_idl) else $error("read data held");
  property p_err; psel && !penable && paddr > 12'h018 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
endmodule : cip_asserts
bind cip_top cip_asserts cip_asserts_inst (.*);

// ---- tb/cip_src.sv ----
// request source model: a held fire command gives one-cycle request pulses
// assumes fire is driven in the pclk domain
`timescale 1ns/1ns
module cip_src (
  input wire logic pclk,
  input wire logic [5:0] fire,
  output logic [5:0] req
);
  logic [5:0] last = 6'h00;
  always @(posedge pclk)
  begin
    req <= fire & ~last;
    last <= fire;
  end
endmodule : cip_src

// ---- tb/testbench.sv ----
// self-checking bench for the cpu priority and flag block
// assumes cip_top, its checker and the source model are compiled first
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, user_irq_block, irq;
  logic ext_req_two, ext_req_one, change_req, comparator_req, i2c_master_req, i2c_slave_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] cpu_level;
  logic [5:0] fire, req;
  int n_errors, n_checks;
  assign {ext_req_two, ext_req_one, change_req, comparator_req, i2c_master_req} = req[5:1];
  assign i2c_slave_req = req[0];
  cip_top cip_top_inst (.*);
  cip_src cip_src_inst (.pclk(pclk), .fire(fire), .req(req));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'h1 && i < 9);
    rv = prdata;
    {psel, penable} <= 2'h0;
    if (pready !== 1'h1)
    begin
      n_errors++;
      stop_test();
    end
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rv, e);
  endtask : rd
  task automatic t_level;
    acc(1'h1, 12'h000, 32'hE0);
    @(negedge pclk);
    chk({cpu_level, user_irq_block}, 5'h0F);
    acc(1'h1, 12'h000, 32'h60);
    rd(12'h000, 32'h60);
    chk({cpu_level, user_irq_block}, 5'h06);
    acc(1'h1, 12'h008, 32'h8000);
    acc(1'h1, 12'h000, 32'hA0);
    rd(12'h000, 32'h60);
    acc(1'h1, 12'h008, 32'h0);
    acc(1'h1, 12'h000, 32'hA0);
    rd(12'h000, 32'hA0);
    acc(1'h1, 12'h004, 32'h8);
    rd(12'h004, 32'h0);
  endtask : t_level
  task automatic t_flags;
    acc(1'h1, 12'h014, 32'h1);
    @(posedge pclk);
    fire <= 6'h3F;
    repeat (2) @(posedge pclk);
    fire <= 6'h00;
    rd(12'h00C, 32'h201F);
    chk(irq, 1'h1);
    acc(1'h1, 12'h018, 32'h201E);
    rd(12'h00C, 32'h1);
    acc(1'h1, 12'h018, 32'h1);
    rd(12'h00C, 32'h0);
    chk(irq, 1'h0);
    acc(1'h1, 12'h00C, 32'hFFFF);
    acc(1'h1, 12'h014, 32'h0);
    rd(12'h00C, 32'h201F);
    chk(irq, 1'h0);
  endtask : t_flags
  task automatic t_adc;
    rd(12'h010, 32'h44);
    acc(1'h1, 12'h010, 32'hFFFF);
    rd(12'h010, 32'h77);
    acc(1'h0, 12'h040, 32'h0);
    chk(pslverr, 1'h1);
  endtask : t_adc
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_adc();
    t_level();
    t_flags();
    stop_test();
  end
endmodule : testbench
